/* File: rtl/sfs_phase_seq.sv */
/*
 * Serial flash IO phase sequencer, device end. After the instruction it runs
 * address/mode input, latency and data output phases in single, dual, quad
 * and DDR quad widths, plus a buffered page program into a small array.
 * Assumes the host drives sck_i (mode 0) and cs_n_i; configuration inputs are
 * quasi-static levels on the reference clock.
 */
`timescale 1ns/1ps
module sfs_phase_seq
	import sfs_pkg::*;
#(
	parameter int POR_CYCLES = sfs_pkg::POR_CYCLES
) (
	// reference clock and reset
	input  wire logic                      ref_clk_i,
	input  wire logic                      rst_i,
	// configuration levels
	input  wire logic [sfs_pkg::LAT_W-1:0] latency_code_i,
	input  wire logic                      quad_enable_i,
	input  wire logic                      four_wire_instruction_mode_i,
	input  wire logic                      data_training_pattern_en_i,
	input  wire logic [sfs_pkg::PAT_W-1:0] data_training_pattern_i,
	// serial link
	input  wire logic                      sck_i,
	input  wire logic                      cs_n_i,
	input  wire logic [3:0]                io_i,
	output logic      [3:0]                io_o,
	output logic      [3:0]                io_oe_o,
	// status
	output logic                           ready_o,
	output logic                           deep_power_down_o,
	output logic                           frame_active_o
);

	localparam int POR_W = $clog2(POR_CYCLES + 1);

	if (POR_CYCLES < 1) begin : g_bad_por
		$error("sfs_phase_seq: POR_CYCLES must be at least 1");
	end

	// reference domain
	logic             link_rst_q;
	logic [POR_W-1:0] por_cnt_q;
	logic             ready_q;
	logic [1:0]       st_s;

	// link domain, synchronised configuration
	logic [15:0]       cfg_s;
	logic              c_rdy;
	logic [LAT_W-1:0]  c_lat;
	logic              c_qe;
	logic              c_qpi;
	logic              c_ten;
	logic [PAT_W-1:0]  c_pat;

	// link domain, frame state
	sfs_state_t        state_q;
	logic [5:0]        cnt_q;
	logic [7:0]        cmd_sh_q;
	logic [31:0]       r_sh_q;
	logic [1:0]        abpc_q;
	logic [1:0]        obpc_q;
	logic              mode_q;
	logic              rd_q;
	logic [LAT_W-1:0]  lat_q;
	logic [5:0]        aclk_q;
	logic [3:0]        ddr_lo_q;
	logic [15:0]       f_sh_q;
	logic [2:0]        fcnt_q;
	logic [7:0]        cur_q;
	logic [2:0]        obit_q;
	logic [IDX_W-1:0]  oidx_q;
	logic              ostart_q;
	logic [3:0]        nout_q;
	logic [3:0]        noe_q;
	logic [3:0]        lo_nib_q;

	// link domain, state that outlives a frame
	logic              dpd_q;
	logic              pend_q;
	logic [2:0]        wpart_q;
	logic [IDX_W-1:0]  woff_q;
	logic [7:0]        wsh_q;
	logic [DEPTH-1:0]  svld_q;
	logic [7:0]        stage_q [DEPTH];
	logic [7:0]        mem_q   [DEPTH];

	// combinational
	logic              qpi_on;
	logic              cmd_last;
	logic              addr_last;
	logic              frame_first;
	logic [7:0]        cmd_nx;
	logic              d_ok;
	logic              d_rd;
	logic              d_mode;
	logic [1:0]        d_abpc;
	logic [1:0]        d_obpc;
	logic [LAT_W-1:0]  d_lat;
	logic [IDX_W-1:0]  start_idx;
	logic [7:0]        wsh_nx;
	logic [2:0]        wpart_nx;
	logic [7:0]        obyte;
	logic [7:0]        oshift;
	logic [2:0]        ostep;
	logic              train;
	logic [5:0]        tpos;
	logic [PAT_W-1:0]  pat_sh;

	// reset for the link domain comes from a flop, never straight from the pin
	always_ff @(posedge ref_clk_i) begin
		link_rst_q <= rst_i;
	end

	// power-up timer; the link refuses commands until it expires
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			por_cnt_q <= '0;
			ready_q   <= 1'b0;
		end else if (!ready_q) begin
			if (por_cnt_q == POR_W'(POR_CYCLES - 1)) begin
				ready_q <= 1'b1;
			end else begin
				por_cnt_q <= por_cnt_q + 1'b1;
			end
		end
	end

	// status levels into the reference domain
	sfs_sync #(.W(2)) u_st_sync (
		.clk_i  (ref_clk_i),
		.arst_i (1'b0),
		.d_i    ({dpd_q, ~cs_n_i}),
		.q_o    (st_s)
	);

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ready_o           <= 1'b0;
			deep_power_down_o <= 1'b0;
			frame_active_o    <= 1'b0;
		end else begin
			ready_o           <= ready_q;
			deep_power_down_o <= st_s[1];
			frame_active_o    <= st_s[0];
		end
	end

	// configuration into the link domain; settles within two sck edges,
	// which the eight single-wire instruction clocks cover, but the two four-wire ones do not
	sfs_sync #(.W(16)) u_cfg_sync (
		.clk_i  (sck_i),
		.arst_i (link_rst_q),
		.d_i    ({ready_q, latency_code_i, quad_enable_i, four_wire_instruction_mode_i,
		          data_training_pattern_en_i, data_training_pattern_i}),
		.q_o    (cfg_s)
	);

	assign {c_rdy, c_lat, c_qe, c_qpi, c_ten, c_pat} = cfg_s;
	assign qpi_on      = c_qpi & c_qe;
	assign cmd_nx      = qpi_on ? {cmd_sh_q[3:0], io_i} : {cmd_sh_q[6:0], io_i[0]};
	assign cmd_last    = (state_q == ST_CMD) && (cnt_q[2:0] == (qpi_on ? 3'h1 : 3'h7));
	assign addr_last   = (state_q == ST_ADDR) && (cnt_q == aclk_q - 6'h01);
	assign frame_first = (state_q == ST_CMD) && (cnt_q == 6'h00);

	// first array index: low address nibble, placed by width and mode byte
	always_comb begin
		if (abpc_q == BPC_8) begin
			start_idx = f_sh_q[7:4];
		end else if (mode_q) begin
			start_idx = r_sh_q[11:8];
		end else begin
			start_idx = r_sh_q[3:0];
		end
	end

	// instruction decode; write protect is never looked at
	always_comb begin
		d_ok   = 1'b0;
		d_rd   = 1'b1;
		d_mode = 1'b0;
		d_abpc = qpi_on ? BPC_4 : BPC_1;
		d_obpc = qpi_on ? BPC_4 : BPC_1;
		d_lat  = c_lat;
		case (cmd_nx)
			CMD_READ: begin
				d_ok  = 1'b1;
				d_lat = '0;
			end
			CMD_FAST_READ, CMD_OTP_AREA_READ, CMD_ANY_REGISTER_READ: begin
				d_ok = 1'b1;
			end
			CMD_PARAM_TABLE_READ: begin
				d_ok  = 1'b1;
				d_lat = PARAM_TABLE_LAT;
			end
			CMD_DUAL_OUT_READ: begin
				d_ok   = !qpi_on;
				d_obpc = BPC_2;
			end
			CMD_DUAL_IO_READ: begin
				d_ok   = !qpi_on;
				d_mode = 1'b1;
				d_abpc = BPC_2;
				d_obpc = BPC_2;
			end
			CMD_QUAD_OUT_READ: begin
				d_ok   = c_qe;
				d_obpc = BPC_4;
			end
			CMD_QUAD_IO_READ: begin
				d_ok   = c_qe;
				d_mode = 1'b1;
				d_abpc = BPC_4;
				d_obpc = BPC_4;
			end
			CMD_DDR_QUAD_IO_READ: begin
				d_ok   = c_qe;
				d_mode = 1'b1;
				d_abpc = BPC_8;
				d_obpc = BPC_8;
				if (c_lat == '0) begin
					d_lat = DDR_MIN_LAT;
				end
			end
			CMD_PAGE_PROGRAM: begin
				d_ok  = 1'b1;
				d_rd  = 1'b0;
				d_lat = '0;
			end
			default: begin
				d_ok = 1'b0;
			end
		endcase
	end

	// phase sequencing; select high returns the interface to standby
	always_ff @(posedge sck_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			state_q  <= ST_CMD;
			cnt_q    <= '0;
			cmd_sh_q <= '0;
			r_sh_q   <= '0;
			abpc_q   <= BPC_1;
			obpc_q   <= BPC_1;
			mode_q   <= 1'b0;
			rd_q     <= 1'b0;
			lat_q    <= '0;
			aclk_q   <= '0;
		end else begin
			case (state_q)
				ST_CMD: begin
					cmd_sh_q <= cmd_nx;
					cnt_q    <= cnt_q + 6'h01;
					if (cmd_last) begin
						cnt_q  <= '0;
						abpc_q <= d_abpc;
						obpc_q <= d_obpc;
						mode_q <= d_mode;
						rd_q   <= d_rd;
						lat_q  <= d_lat;
						aclk_q <= 6'((d_mode ? 32 : 24) >> d_abpc);
						// refused commands fall silent until deselect
						if (!c_rdy || dpd_q || !d_ok) begin
							state_q <= ST_IGNORE;
						end else begin
							state_q <= ST_ADDR;
						end
					end
				end
				ST_ADDR: begin
					cnt_q <= cnt_q + 6'h01;
					case (abpc_q)
						BPC_1:   r_sh_q <= {r_sh_q[30:0], io_i[0]};
						BPC_2:   r_sh_q <= {r_sh_q[29:0], io_i[1:0]};
						default: r_sh_q <= {r_sh_q[27:0], io_i};
					endcase
					if (addr_last) begin
						cnt_q <= '0;
						if (!rd_q) begin
							state_q <= ST_WDATA;
						end else if (lat_q == '0) begin
							state_q <= ST_OUT;
						end else begin
							state_q <= ST_LAT;
						end
					end
				end
				ST_LAT: begin
					// io_i is not looked at here
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q == {2'h0, lat_q} - 6'h01) begin
						state_q <= ST_OUT;
					end
				end
				ST_OUT, ST_WDATA, ST_IGNORE: begin
					state_q <= state_q;
				end
				default: begin
					state_q <= ST_IGNORE;
				end
			endcase
		end
	end

	// falling-edge nibbles of the DDR address; the falling edge of the last
	// instruction clock carries no address, and the last nibble lands in latency
	always_ff @(negedge sck_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			f_sh_q <= '0;
			fcnt_q <= '0;
		end else if (abpc_q == BPC_8 && !fcnt_q[2] &&
		             ((state_q == ST_ADDR && cnt_q != 6'h00) || state_q == ST_LAT)) begin
			f_sh_q <= {f_sh_q[11:0], io_i};
			fcnt_q <= fcnt_q + 3'h1;
		end
	end

	// deep power-down; only the release code is heard while asleep
	always_ff @(posedge sck_i or posedge link_rst_q) begin
		if (link_rst_q) begin
			dpd_q <= 1'b0;
		end else if (cmd_last && c_rdy) begin
			if (dpd_q && cmd_nx == CMD_POWER_DOWN_RELEASE) begin
				dpd_q <= 1'b0;
			end else if (!dpd_q && cmd_nx == CMD_DEEP_POWER_DOWN) begin
				dpd_q <= 1'b1;
			end
		end
	end

	assign wsh_nx   = (abpc_q == BPC_4) ? {wsh_q[3:0], io_i} : {wsh_q[6:0], io_i[0]};
	assign wpart_nx = wpart_q + ((abpc_q == BPC_4) ? 3'h4 : 3'h1);

	// program staging; the sck stops at deselect, so the commit waits for
	// the first edge of the next frame, where the byte count is judged
	always_ff @(posedge sck_i or posedge link_rst_q) begin
		if (link_rst_q) begin
			pend_q  <= 1'b0;
			wpart_q <= '0;
			woff_q  <= '0;
			wsh_q   <= '0;
			svld_q  <= '0;
		end else if (addr_last && !rd_q) begin
			pend_q  <= 1'b1;
			wpart_q <= '0;
			woff_q  <= '0;
			svld_q  <= '0;
		end else if (state_q == ST_WDATA) begin
			wsh_q   <= wsh_nx;
			wpart_q <= wpart_nx;
			if (wpart_nx == 3'h0) begin
				svld_q[start_idx + woff_q] <= 1'b1;
				woff_q                     <= woff_q + 1'b1;
			end
		end else if (frame_first) begin
			pend_q <= 1'b0;
		end
	end

	// staged bytes carry data only, so they need no reset
	always_ff @(posedge sck_i) begin
		if (state_q == ST_WDATA && wpart_nx == 3'h0) begin
			stage_q[start_idx + woff_q] <= wsh_nx;
		end
	end

	// array entries; a ragged final byte drops the whole program silently
	for (genvar i = 0; i < DEPTH; i++) begin : g_mem
		always_ff @(posedge sck_i or posedge link_rst_q) begin
			if (link_rst_q) begin
				mem_q[i] <= '0;
			end else if (frame_first && pend_q && wpart_q == 3'h0 && svld_q[i]) begin
				mem_q[i] <= stage_q[i];
			end
		end
	end

	// next output byte and its shifted remainder
	assign obyte = (obit_q == 3'h0) ? mem_q[ostart_q ? oidx_q : start_idx] : cur_q;

	always_comb begin
		case (obpc_q)
			BPC_1: begin
				ostep  = 3'h1;
				oshift = {obyte[6:0], 1'h0};
			end
			BPC_2: begin
				ostep  = 3'h2;
				oshift = {obyte[5:0], 2'h0};
			end
			BPC_4: begin
				ostep  = 3'h4;
				oshift = {obyte[3:0], 4'h0};
			end
			default: begin
				ostep  = 3'h0;
				oshift = 8'h00;
			end
		endcase
	end

	// training window: the last four latency cycles of a DDR read
	assign tpos   = cnt_q + TRAIN_CYCLES - {2'h0, lat_q};
	assign train  = (state_q == ST_LAT) && obpc_q == BPC_8 && c_ten && !tpos[5] && tpos < TRAIN_CYCLES;
	assign pat_sh = c_pat << {tpos[1:0], 1'h0};

	// pins change on the falling edge so the host samples on the rising one
	always_ff @(negedge sck_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			cur_q    <= '0;
			obit_q   <= '0;
			oidx_q   <= '0;
			ostart_q <= 1'b0;
			nout_q   <= '0;
			noe_q    <= '0;
			lo_nib_q <= '0;
		end else if (state_q == ST_OUT) begin
			ostart_q <= 1'b1;
			obit_q   <= obit_q + ostep;
			cur_q    <= oshift;
			if (obit_q == 3'h0) begin
				oidx_q <= (ostart_q ? oidx_q : start_idx) + 1'b1;
			end
			case (obpc_q)
				BPC_1: begin
					nout_q <= {2'h0, obyte[7], 1'h0};
					noe_q  <= 4'h2;
				end
				BPC_2: begin
					nout_q <= {2'h0, obyte[7:6]};
					noe_q  <= 4'h3;
				end
				default: begin
					nout_q   <= obyte[7:4];
					lo_nib_q <= obyte[3:0];
					noe_q    <= 4'hf;
				end
			endcase
		end else if (train) begin
			nout_q   <= {4{pat_sh[7]}};
			lo_nib_q <= {4{pat_sh[6]}};
			noe_q    <= 4'hf;
		end else begin
			// every other phase, latency included, leaves the lines floating
			nout_q <= '0;
			noe_q  <= '0;
		end
	end

	// second half of each DDR clock carries the low nibble
	always_ff @(posedge sck_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			ddr_lo_q <= '0;
		end else begin
			ddr_lo_q <= lo_nib_q;
		end
	end

	// DDR needs a data change on both edges, so one level mux on sck is kept
	assign io_o    = (obpc_q == BPC_8 && sck_i) ? ddr_lo_q : nout_q;
	assign io_oe_o = noe_q;

endmodule : sfs_phase_seq

/* File: rtl/sfs_pkg.sv */
/*
 * Shared constants for the serial flash IO phase sequencer: command codes,
 * transfer widths, latency figures, power-up timing and the link state type.
 * Assumes a 100 MHz reference clock and 24-bit addressing.
 */
package sfs_pkg;

	// array geometry and field widths
	localparam int ADDR_W = 24;
	localparam int MODE_W = 8;
	localparam int DEPTH  = 16;
	localparam int IDX_W  = 4;
	localparam int LAT_W  = 4;
	localparam int PAT_W  = 8;

	// command codes
	localparam logic [7:0] CMD_READ             = 8'h03;
	localparam logic [7:0] CMD_FAST_READ        = 8'h0b;
	localparam logic [7:0] CMD_DUAL_OUT_READ    = 8'h3b;
	localparam logic [7:0] CMD_DUAL_IO_READ     = 8'hbb;
	localparam logic [7:0] CMD_QUAD_OUT_READ    = 8'h6b;
	localparam logic [7:0] CMD_QUAD_IO_READ     = 8'heb;
	localparam logic [7:0] CMD_DDR_QUAD_IO_READ = 8'hed;
	localparam logic [7:0] CMD_PARAM_TABLE_READ = 8'h5a;
	localparam logic [7:0] CMD_OTP_AREA_READ    = 8'h4b;
	localparam logic [7:0] CMD_ANY_REGISTER_READ = 8'h65;
	localparam logic [7:0] CMD_PAGE_PROGRAM     = 8'h02;
	localparam logic [7:0] CMD_DEEP_POWER_DOWN  = 8'hb9;
	localparam logic [7:0] CMD_POWER_DOWN_RELEASE = 8'hab;

	// bits per clock, as a power of two
	localparam logic [1:0] BPC_1 = 2'h0;
	localparam logic [1:0] BPC_2 = 2'h1;
	localparam logic [1:0] BPC_4 = 2'h2;
	localparam logic [1:0] BPC_8 = 2'h3;

	// latency figures
	localparam logic [LAT_W-1:0] PARAM_TABLE_LAT = 4'h8;
	localparam logic [LAT_W-1:0] DDR_MIN_LAT     = 4'h1;
	localparam logic [5:0]       TRAIN_CYCLES    = 6'h04;

	// power-up time
	localparam int T_PU_US    = 300;
	localparam int REF_MHZ    = 100;
	localparam int POR_CYCLES = T_PU_US * REF_MHZ;

	// link phase, one-hot
	typedef enum logic [5:0] {
		ST_CMD    = 6'h01,
		ST_ADDR   = 6'h02,
		ST_LAT    = 6'h04,
		ST_OUT    = 6'h08,
		ST_WDATA  = 6'h10,
		ST_IGNORE = 6'h20
	} sfs_state_t;

endpackage : sfs_pkg

/* File: rtl/sfs_sync.sv */
/*
 * Two-flop level synchroniser, W bits wide.
 * Assumes each bit is a slow level; multi-bit values must be quasi-static.
 */
`timescale 1ns/1ps
module sfs_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         arst_i,
	// level in and out
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] meta_q;

	if (W < 1) begin : g_bad_width
		$error("sfs_sync: W must be at least 1");
	end

	// first stage feeds only the second
	always_ff @(posedge clk_i or posedge arst_i) begin
		if (arst_i) begin
			meta_q <= '0;
			q_o    <= '0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end

endmodule : sfs_sync

/* File: verif/sfs_host_model.sv */
/* Behavioural host controller: makes sck and select, drives and resolves IO.
 * Assumes the bench calls its tasks one at a time. */
`timescale 1ns/1ps
module sfs_host_model (
	// link out
	output logic            sck_o,
	output logic            cs_n_o,
	output wire logic [3:0] io_o,
	// device pins
	input  wire logic [3:0] dev_io_i,
	input  wire logic [3:0] dev_oe_i
);
	logic [3:0] h_io;
	logic [3:0] h_oe;
	logic       flt;

	// released lines flip every cycle so a stale value is never read
	assign io_o = (dev_oe_i & dev_io_i) | (~dev_oe_i & h_oe & h_io) | (~dev_oe_i & ~h_oe & {4{flt}});

	// link idle: clock stands low, select high
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b0;
		h_io = 4'h0;
		h_oe = 4'h0;
		flt = 1'b0;
		// a sure rising select edge puts the frame state in standby before any check
		#1 cs_n_o = 1'b1;
	end

	// one cycle: drive in the low half, sample before each edge
	task automatic cyc(input logic [3:0] d, input logic [3:0] e, output logic [3:0] h, output logic [3:0] l,
		output logic [3:0] o);
		h_io = d;
		h_oe = e;
		flt = ~flt;
		#31;
		h = io_o;
		o = dev_oe_i;
		#1 sck_o = 1'b1;
		#31;
		l = io_o;
		o = o | dev_oe_i;
		#1 sck_o = 1'b0;
	endtask : cyc

	// select low, instruction, then zero address at am lanes
	task automatic head(input logic [7:0] c, input logic qp, input int na, input logic [3:0] am);
		logic [3:0] h, l, o;
		cs_n_o = 1'b0;
		if (qp) begin
			cyc(c[7:4], 4'hf, h, l, o);
			cyc(c[3:0], 4'hf, h, l, o);
		end else begin
			for (int i = 7; i >= 0; i--) cyc({3'h0, c[i]}, 4'h1, h, l, o);
		end
		for (int i = 0; i < na; i++) cyc(4'h0, am, h, l, o);
	endtask : head

	// end of frame with the clock low
	task automatic fin();
		#32 cs_n_o = 1'b1;
		h_oe = 4'h0;
		#96;
	endtask : fin

	// program at address zero, nb data bits msb first
	task automatic pg(input int nb, input logic [15:0] d);
		logic [3:0] h, l, o;
		head(8'h02, 1'b0, 24, 4'h1);
		for (int i = 0; i < nb; i++) cyc({3'h0, d[15-i]}, 4'h1, h, l, o);
		fin();
	endtask : pg

	// read two bytes; reports enables in latency and first data cycle
	task automatic rd(input logic [7:0] c, input logic qp, input int na, input logic [3:0] am, input int nl,
		input int tr, input int ow, output logic [15:0] dat, output logic [3:0] oel, output logic [3:0] oeo,
		output logic [7:0] trn);
		logic [3:0] h, l, o;
		dat = 16'h0;
		oel = 4'h0;
		oeo = 4'h0;
		trn = 8'h0;
		head(c, qp, na, am);
		for (int i = 0; i < nl; i++) begin
			cyc(4'h0, 4'h0, h, l, o); // host floats all latency
			if (i < nl - tr) oel = oel | o;
			else trn = {trn[5:0], h[0], l[0]};
		end
		for (int i = 0; i < 16 / ow; i++) begin
			cyc(4'h0, 4'h0, h, l, o);
			if (i == 0) oeo = o;
			case (ow)
				1: dat = {dat[14:0], h[1]};
				2: dat = {dat[13:0], h[1:0]};
				4: dat = {dat[11:0], h};
				default: dat = {dat[7:0], h, l};
			endcase
		end
		fin();
	endtask : rd
endmodule : sfs_host_model

/* File: verif/sfs_phase_seq_assertions.sv */
/* Concurrent checks on the sequencer's ports.
 * Assumes it is bound onto sfs_phase_seq and gets the same POR_CYCLES. */
`timescale 1ns/1ps
module sfs_phase_seq_assertions #(
	parameter int POR_CYCLES = 20
) (
	// clocks and reset
	input wire logic       ref_clk_i,
	input wire logic       rst_i,
	input wire logic       sck_i,
	// configuration and link
	input wire logic       quad_enable_i,
	input wire logic       four_wire_instruction_mode_i,
	input wire logic       cs_n_i,
	input wire logic [3:0] io_oe_o,
	// status
	input wire logic       ready_o,
	input wire logic       deep_power_down_o,
	input wire logic       frame_active_o
);
	int         por_cnt;
	logic [7:0] edge_cnt;

	// reference edges since reset release; saturates so it never wraps
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			por_cnt <= 32'h0;
		end else if (por_cnt < 32'hffff) begin
			por_cnt <= por_cnt + 32'h1;
		end
	end

	// rising link edges in this frame; select high clears it at once
	always_ff @(posedge sck_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			edge_cnt <= 8'h00;
		end else if (edge_cnt != 8'hff) begin
			edge_cnt <= edge_cnt + 8'h01;
		end
	end

	chk_idle_no_drive: assert property (
		@(posedge ref_clk_i) disable iff (rst_i) cs_n_i |-> io_oe_o == 4'h0)
		else $error("pins driven while deselected");
	chk_early_silent: assert property (
		@(posedge ref_clk_i) disable iff (rst_i) !ready_o |-> io_oe_o == 4'h0)
		else $error("pins driven before power-up done");
	chk_ready_time: assert property (
		@(posedge ref_clk_i) disable iff (rst_i) $rose(ready_o) |-> por_cnt >= POR_CYCLES - 1 && por_cnt <= POR_CYCLES + 3)
		else $error("ready at wrong time");
	chk_ready_stays: assert property (
		@(posedge ref_clk_i) disable iff (rst_i) ready_o |=> ready_o)
		else $error("ready dropped");
	chk_quad_pins: assert property (
		@(posedge ref_clk_i) disable iff (rst_i) !quad_enable_i |-> io_oe_o[3:2] == 2'h0)
		else $error("upper pins driven without quad enable");
	chk_drive_width: assert property (
		@(posedge ref_clk_i) disable iff (rst_i) io_oe_o inside {4'h0, 4'h2, 4'h3, 4'hf})
		else $error("illegal pin enable mix");
	chk_sleep_silent: assert property (
		@(posedge ref_clk_i) disable iff (rst_i) deep_power_down_o |-> io_oe_o == 4'h0)
		else $error("pins driven in power-down");
	chk_frame_seen: assert property (
		@(posedge ref_clk_i) disable iff (rst_i) $fell(cs_n_i) |-> ##[1:5] frame_active_o)
		else $error("frame not flagged");
	chk_single_turn: assert property (
		@(negedge sck_i) disable iff (cs_n_i)
		io_oe_o == 4'h2 && !four_wire_instruction_mode_i |-> edge_cnt >= 8'h21)
		else $error("single output too early");
	chk_dual_turn: assert property (
		@(negedge sck_i) disable iff (cs_n_i) io_oe_o == 4'h3 |-> edge_cnt >= 8'h19)
		else $error("dual output too early");
endmodule : sfs_phase_seq_assertions

bind sfs_phase_seq sfs_phase_seq_assertions #(.POR_CYCLES(POR_CYCLES)) chk_u (
	.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sck_i(sck_i), .quad_enable_i(quad_enable_i),
	.four_wire_instruction_mode_i(four_wire_instruction_mode_i), .cs_n_i(cs_n_i), .io_oe_o(io_oe_o),
	.ready_o(ready_o), .deep_power_down_o(deep_power_down_o), .frame_active_o(frame_active_o));

/* File: verif/sfs_phase_seq_tb_top.sv */
/* Self-checking bench: host model runs frames, compare tasks judge them.
 * Assumes the power-up count is shortened to 200 reference cycles. */
`timescale 1ns/1ps
module sfs_phase_seq_tb_top;
	logic                      ref_clk_i;
	logic                      rst_i;
	logic [sfs_pkg::LAT_W-1:0] lat_code;
	logic                      quad_en;
	logic                      four_wire;
	logic                      train_en;
	logic [sfs_pkg::PAT_W-1:0] train_pat;
	wire logic                 sck;
	wire logic                 cs_n;
	wire logic [3:0]           io_w;
	wire logic [3:0]           dev_io;
	wire logic [3:0]           dev_oe;
	wire logic                 ready;
	wire logic                 deep_power_down;
	int                        n_errors;
	int                        cmp_count;

	sfs_phase_seq #(.POR_CYCLES(200)) dut_u (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .latency_code_i(lat_code), .quad_enable_i(quad_en),
		.four_wire_instruction_mode_i(four_wire), .data_training_pattern_en_i(train_en),
		.data_training_pattern_i(train_pat), .sck_i(sck), .cs_n_i(cs_n), .io_i(io_w), .io_o(dev_io),
		.io_oe_o(dev_oe), .ready_o(ready), .deep_power_down_o(deep_power_down), .frame_active_o());
	sfs_host_model host_u (.sck_o(sck), .cs_n_o(cs_n), .io_o(io_w), .dev_io_i(dev_io), .dev_oe_i(dev_oe));

	// 100 MHz reference clock
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	task automatic cmp_data(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp_data

	task automatic cmp_flag(input string nm, input logic [3:0] e, input logic [3:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp_flag

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : summarize

	// config changes only between frames; a dummy frame clocks the link sync
	task automatic cfg(input logic [3:0] l, input logic q, input logic w, input logic t);
		@(posedge ref_clk_i);
		lat_code <= l;
		quad_en <= q;
		four_wire <= w;
		train_en <= t;
		repeat (2) @(posedge ref_clk_i);
		host_u.head(8'h00, 1'b1, 0, 4'h0);
		host_u.fin();
	endtask : cfg

	// one read; eo is the expected enable, zero for a refused command
	task automatic rdck(input logic [7:0] c, input logic qp, input int na, input logic [3:0] am, input int nl,
		input int tr, input int ow, input logic [3:0] eo);
		logic [15:0] d;
		logic [3:0]  ol, oo;
		logic [7:0]  t;
		host_u.rd(c, qp, na, am, nl, tr, ow, d, ol, oo, t);
		cmp_flag("latency enable", 4'h0, ol); // quiet latency
		cmp_flag("output enable", eo, oo); // data from first cycle
		if (eo != 4'h0) cmp_data("read data", 16'ha53c, d); // lanes and order
		if (tr != 0) cmp_data("training", {8'h0, train_pat}, {8'h0, t}); // last four cycles
	endtask : rdck

	// main sequence; training only ever with latency five
	initial begin
		n_errors = 0;
		cmp_count = 0;
		rst_i = 1'b1;
		lat_code = 4'h3;
		quad_en = 1'b0;
		four_wire = 1'b0;
		train_en = 1'b0;
		train_pat = 8'h96;
		repeat (4) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		rdck(8'h03, 1'b0, 24, 4'h1, 0, 0, 1, 4'h0); // refused early
		for (int i = 0; i < 1000 && ready !== 1'b1; i++) @(posedge ref_clk_i);
		cmp_flag("ready", 4'h1, {3'h0, ready});
		$display("test power-up done");
		cfg(4'h3, 1'b0, 1'b0, 1'b0);
		host_u.pg(16, 16'ha53c);
		host_u.pg(15, 16'hffff);
		rdck(8'h03, 1'b0, 24, 4'h1, 0, 0, 1, 4'h2); // partial program dropped, no latency
		$display("test program done");
		rdck(8'h0b, 1'b0, 24, 4'h1, 3, 0, 1, 4'h2); // code sets latency
		rdck(8'h5a, 1'b0, 24, 4'h1, 8, 0, 1, 4'h2); // fixed eight
		rdck(8'h4b, 1'b0, 24, 4'h1, 3, 0, 1, 4'h2);
		rdck(8'h65, 1'b0, 24, 4'h1, 3, 0, 1, 4'h2);
		$display("test latency done");
		rdck(8'h3b, 1'b0, 24, 4'h1, 3, 0, 2, 4'h3);
		rdck(8'hbb, 1'b0, 16, 4'h3, 3, 0, 2, 4'h3);
		rdck(8'heb, 1'b0, 8, 4'hf, 3, 0, 4, 4'h0); // no quad enable
		cfg(4'h0, 1'b0, 1'b0, 1'b0);
		rdck(8'hbb, 1'b0, 16, 4'h3, 0, 0, 2, 4'h3); // straight to output
		$display("test dual done");
		cfg(4'h3, 1'b1, 1'b0, 1'b0);
		rdck(8'h6b, 1'b0, 24, 4'h1, 3, 0, 4, 4'hf);
		rdck(8'heb, 1'b0, 8, 4'hf, 3, 0, 4, 4'hf);
		$display("test quad done");
		cfg(4'h5, 1'b1, 1'b0, 1'b1);
		rdck(8'hed, 1'b0, 4, 4'hf, 5, 4, 8, 4'hf);
		$display("test ddr done");
		cfg(4'h3, 1'b1, 1'b1, 1'b0);
		rdck(8'heb, 1'b1, 8, 4'hf, 3, 0, 4, 4'hf); // nibble instruction
		rdck(8'hbb, 1'b1, 16, 4'h3, 3, 0, 2, 4'h0); // dual refused in this mode
		$display("test instruction mode done");
		cfg(4'h3, 1'b0, 1'b0, 1'b0);
		host_u.head(8'hb9, 1'b0, 0, 4'h0);
		host_u.fin();
		rdck(8'h03, 1'b0, 24, 4'h1, 0, 0, 1, 4'h0); // ignored asleep
		cmp_flag("power-down", 4'h1, {3'h0, deep_power_down});
		host_u.head(8'hab, 1'b0, 0, 4'h0);
		host_u.fin();
		rdck(8'h03, 1'b0, 24, 4'h1, 0, 0, 1, 4'h2); // awake again
		cmp_flag("power-down", 4'h0, {3'h0, deep_power_down});
		$display("test power-down done");
		summarize();
	end

	// whole run needs about 54 us; eleven times that means a hang
	initial begin
		#600000;
		n_errors++;
		summarize();
	end
endmodule : sfs_phase_seq_tb_top
